// file: design/aere_consts.svh
// Summary of operation
// RQ1: one enable bit per analog input
// RQ2: all analog inputs enabled after reset
// RQ3: error on map write touching active feedback
// RQ4: feedback input follows its owning axis
// RQ5: scan dwell 40 or 25 us per channel
// RQ6: sample interval is dwell times enabled count
// RQ7: disabled channels are skipped by scan
// RQ8: eight encoder enables, clear by default
// RQ9: enable bits of mapped encoders ignored
// RQ10: bits of absent encoders ignored
// RQ11: feedback encoder follows its owning axis
// RQ12: error when too many encoders requested
// RQ13: direct output code signed sixteen bit
// RQ14: direct code bypasses limit and offset
// RQ15: host must not write mapped outputs
// RQ16: enabled axis discards direct output code
// RQ17: scan ascends and wraps to lowest enabled
`ifndef AERE_CONSTS_SVH
`define AERE_CONSTS_SVH
`define AERE_ADC_EN_OFS 12'h000
`define AERE_ENC_EN_OFS 12'h004
`define AERE_AXIS_EN_OFS 12'h008
`define AERE_ADC_FB_OFS 12'h00c
`define AERE_ENC_FB_OFS 12'h010
`define AERE_DAC_MAP_OFS 12'h014
`define AERE_DAC_SEL_OFS 12'h018
`define AERE_DAC_CODE_OFS 12'h01c
`define AERE_CFG_OFS 12'h020
`define AERE_STAT_OFS 12'h024
`define AERE_IRQ_STAT_OFS 12'h028
`define AERE_IRQ_MASK_OFS 12'h02c
`define AERE_SCAN_OFS 12'h030
`define AERE_ADC_EN_RST 8'hff
`define AERE_ENC_EN_RST 8'h00
`define AERE_DWELL_SLOW_NS 40000
`define AERE_DWELL_FAST_NS 25000
`define AERE_CLK_NS 20
`define AERE_IRQ_ADC_ERR 0
`define AERE_IRQ_ENC_ERR 1
`define AERE_IRQ_DAC_DROP 2
`define AERE_IRQ_SCAN_WRAP 3
`endif

// file: design/aere_pkg.sv
package aere_pkg;
    typedef struct packed {
        logic valid;
        logic [2:0] chan;
    } aere_scan_t;
    typedef struct packed {
        logic valid;
        logic [2:0] chan;
        logic signed [15:0] code;
    } aere_dac_t;
endpackage : aere_pkg

// file: design/aere_top.sv
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "aere_consts.svh"
module aere_top
    import aere_pkg::*;
#(
    parameter int NUM_ENC = 8,
    parameter int MAX_ENC = 8,
    parameter int DWELL_SLOW = `AERE_DWELL_SLOW_NS / `AERE_CLK_NS,
    parameter int DWELL_FAST = `AERE_DWELL_FAST_NS / `AERE_CLK_NS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic [7:0] adc_active,
    output logic [7:0] enc_active,
    output aere_scan_t scan,
    output aere_dac_t dac_out
);

    // maps are eight bits wide and the dwell counter sixteen
    if (NUM_ENC < 1 || NUM_ENC > 8 || MAX_ENC < 1 || MAX_ENC > 8 || DWELL_FAST < 1 || DWELL_SLOW < 1 ||
            DWELL_FAST > 65535 || DWELL_SLOW > 65535) begin : g_param_check
        $error("aere_top: unsupported parameters");
    end

    // encoders that exist on this variant, longest dwell in use
    localparam logic [7:0] ENC_PRESENT = 8'((9'h001 << NUM_ENC) - 9'h001);
    localparam logic [15:0] DWELL_MAX = 16'((DWELL_SLOW > DWELL_FAST) ? DWELL_SLOW : DWELL_FAST);

    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    logic wr, rd;
    logic [7:0] adc_en_r, enc_en_r, axis_en_r, adc_fb_r, enc_fb_r, dac_map_r;
    logic [7:0] dac_sel_r, irq_stat_r, irq_mask_r;
    logic fast_r, adc_err_r, enc_err_r;
    logic [3:0] ev;
    logic adc_blocked, enc_too_many, dac_drop, wrap_ev;
    logic [7:0] enc_req, enc_eff;
    logic [3:0] enc_cnt;
    logic [2:0] dac_idx;

    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign pready = 1'b1;

    always_comb begin
        pslverr = 1'b0;
        case (paddr)
            `AERE_ADC_EN_OFS, `AERE_ENC_EN_OFS, `AERE_AXIS_EN_OFS, `AERE_ADC_FB_OFS, `AERE_ENC_FB_OFS,
            `AERE_DAC_MAP_OFS, `AERE_DAC_SEL_OFS, `AERE_DAC_CODE_OFS, `AERE_CFG_OFS, `AERE_STAT_OFS,
            `AERE_IRQ_STAT_OFS, `AERE_IRQ_MASK_OFS, `AERE_SCAN_OFS: pslverr = 1'b0;
            default: pslverr = psel && penable;
        endcase
    end

    // ----------------------------------------------------------------
    // enable maps
    // ----------------------------------------------------------------
    // change of a feedback bit while its axis runs is refused
    assign adc_blocked = ((pwdata[7:0] ^ adc_en_r) & adc_fb_r & axis_en_r) != 8'h00; // RQ3

    always_comb begin
        enc_req = enc_en_r;
        for (int i = 0; i < 8; i++) begin
            if (i < NUM_ENC && !enc_fb_r[i]) // RQ9 RQ10
                enc_req[i] = pwdata[i];
            else
                enc_req[i] = 1'b0;
        end
        enc_eff = enc_req | (enc_fb_r & axis_en_r); // RQ11
        enc_cnt = 4'h0;
        for (int i = 0; i < 8; i++)
            enc_cnt = enc_cnt + {3'h0, enc_eff[i]};
    end
    assign enc_too_many = {28'h0, enc_cnt} > MAX_ENC; // RQ12

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_en_r <= `AERE_ADC_EN_RST; // RQ2
            enc_en_r <= `AERE_ENC_EN_RST; // RQ8
            axis_en_r <= 8'h00;
            adc_fb_r <= 8'h00;
            enc_fb_r <= 8'h00;
            dac_map_r <= 8'h00;
            dac_sel_r <= 8'h00;
            fast_r <= 1'b0;
            adc_err_r <= 1'b0;
            enc_err_r <= 1'b0;
        end else if (wr) begin
            case (paddr)
                `AERE_ADC_EN_OFS: begin
                    adc_err_r <= adc_blocked; // RQ3
                    if (!adc_blocked)
                        adc_en_r <= pwdata[7:0]; // RQ1
                end
                `AERE_ENC_EN_OFS: begin
                    enc_err_r <= enc_too_many; // RQ12
                    if (!enc_too_many)
                        enc_en_r <= enc_req; // RQ8
                end
                `AERE_AXIS_EN_OFS: axis_en_r <= pwdata[7:0];
                `AERE_ADC_FB_OFS: adc_fb_r <= pwdata[7:0];
                `AERE_ENC_FB_OFS: enc_fb_r <= pwdata[7:0];
                `AERE_DAC_MAP_OFS: dac_map_r <= pwdata[7:0];
                `AERE_DAC_SEL_OFS: dac_sel_r <= {5'h00, pwdata[2:0]};
                `AERE_CFG_OFS: fast_r <= pwdata[0];
                default: ;
            endcase
        end
    end

    // feedback channels follow their axis, others the map
    assign adc_active = (adc_en_r & ~adc_fb_r) | (adc_fb_r & axis_en_r); // RQ4
    assign enc_active = (enc_en_r & ~enc_fb_r) | (enc_fb_r & axis_en_r); // RQ11

    // ----------------------------------------------------------------
    // converter scan
    // ----------------------------------------------------------------
    logic [15:0] dwell_r;
    logic [2:0] chan_r;
    logic [2:0] next_chan;
    logic next_found;
    logic [15:0] dwell_len;

    assign dwell_len = fast_r ? 16'(DWELL_FAST) : 16'(DWELL_SLOW); // RQ5

    always_comb begin
        next_chan = chan_r;
        next_found = 1'b0;
        for (int k = 1; k <= 8; k++) begin
            if (!next_found && adc_active[3'(chan_r + 3'(k))]) begin // RQ7 RQ17
                next_chan = 3'(chan_r + 3'(k));
                next_found = 1'b1;
            end
        end
    end
    assign wrap_ev = (dwell_r == 16'h0001) && next_found && (next_chan <= chan_r);

    // each enabled channel gets one dwell per round, so interval = dwell * count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dwell_r <= 16'h0000;
            chan_r <= 3'h7;
        end else if (dwell_r > 16'h0001) begin
            dwell_r <= dwell_r - 16'h0001; // RQ6
        end else if (next_found) begin
            chan_r <= next_chan; // RQ17
            dwell_r <= dwell_len;
        end else begin
            dwell_r <= 16'h0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            scan <= '0;
        else begin
            scan.valid <= (dwell_r == 16'h0001) && adc_active[chan_r]; // RQ7
            scan.chan <= chan_r;
        end
    end

    // ----------------------------------------------------------------
    // direct analog output
    // ----------------------------------------------------------------
    assign dac_idx = dac_sel_r[2:0];
    assign dac_drop = wr && paddr == `AERE_DAC_CODE_OFS && dac_map_r[dac_idx] && axis_en_r[dac_idx]; // RQ16

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            dac_out <= '0;
        else begin
            dac_out.valid <= 1'b0;
            if (wr && paddr == `AERE_DAC_CODE_OFS && !dac_drop) begin
                // raw code passed, no limit or offset applied
                dac_out.valid <= 1'b1; // RQ14
                dac_out.chan <= dac_idx;
                dac_out.code <= pwdata[15:0]; // RQ13
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupts
    // ----------------------------------------------------------------
    assign ev[`AERE_IRQ_ADC_ERR] = wr && paddr == `AERE_ADC_EN_OFS && adc_blocked;
    assign ev[`AERE_IRQ_ENC_ERR] = wr && paddr == `AERE_ENC_EN_OFS && enc_too_many;
    assign ev[`AERE_IRQ_DAC_DROP] = dac_drop;
    assign ev[`AERE_IRQ_SCAN_WRAP] = wrap_ev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= 8'h00;
            irq_mask_r <= 8'h00;
        end else begin
            // set wins over a simultaneous clear
            if (wr && paddr == `AERE_IRQ_STAT_OFS)
                irq_stat_r <= (irq_stat_r & ~pwdata[7:0]) | {4'h0, ev};
            else
                irq_stat_r <= irq_stat_r | {4'h0, ev};
            if (wr && paddr == `AERE_IRQ_MASK_OFS)
                irq_mask_r <= {4'h0, pwdata[3:0]};
        end
    end
    assign irq = (irq_stat_r & irq_mask_r) != 8'h00;

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite) begin
            case (paddr)
                `AERE_ADC_EN_OFS: prdata <= {24'h0, adc_en_r};
                `AERE_ENC_EN_OFS: prdata <= {24'h0, enc_en_r};
                `AERE_AXIS_EN_OFS: prdata <= {24'h0, axis_en_r};
                `AERE_ADC_FB_OFS: prdata <= {24'h0, adc_fb_r};
                `AERE_ENC_FB_OFS: prdata <= {24'h0, enc_fb_r};
                `AERE_DAC_MAP_OFS: prdata <= {24'h0, dac_map_r};
                `AERE_DAC_SEL_OFS: prdata <= {24'h0, dac_sel_r};
                `AERE_DAC_CODE_OFS: prdata <= {16'h0, dac_out.code};
                `AERE_CFG_OFS: prdata <= {31'h0, fast_r};
                `AERE_STAT_OFS: prdata <= {14'h0, enc_err_r, adc_err_r, enc_active, adc_active};
                `AERE_IRQ_STAT_OFS: prdata <= {24'h0, irq_stat_r};
                `AERE_IRQ_MASK_OFS: prdata <= {24'h0, irq_mask_r};
                `AERE_SCAN_OFS: prdata <= {29'h0, chan_r};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_adc_rst;
        @(posedge pclk) $rose(presetn) |-> adc_en_r == 8'hff;
    endproperty
    a_adc_rst: assert property (p_adc_rst) else $error("adc map not all set after reset"); // RQ2

    property p_adc_block;
        @(posedge pclk) disable iff (!presetn)
        wr && paddr == `AERE_ADC_EN_OFS && adc_blocked |=> $stable(adc_en_r) && adc_err_r;
    endproperty
    a_adc_block: assert property (p_adc_block) else $error("blocked adc map write took effect"); // RQ3

    property p_adc_write;
        @(posedge pclk) disable iff (!presetn)
        wr && paddr == `AERE_ADC_EN_OFS && !adc_blocked |=> adc_en_r == $past(pwdata[7:0]);
    endproperty
    a_adc_write: assert property (p_adc_write) else $error("adc map write lost"); // RQ1

    property p_fb_follow;
        @(posedge pclk) disable iff (!presetn)
        ((adc_active & adc_fb_r) == (axis_en_r & adc_fb_r)) && ((enc_active & enc_fb_r) == (axis_en_r & enc_fb_r));
    endproperty
    a_fb_follow: assert property (p_fb_follow) else $error("feedback channel not following axis"); // RQ4

    property p_scan_skip;
        @(posedge pclk) disable iff (!presetn)
        scan.valid |-> $past(adc_active[chan_r]) && scan.chan == $past(chan_r);
    endproperty
    a_scan_skip: assert property (p_scan_skip) else $error("disabled channel sampled"); // RQ7

    property p_dwell;
        @(posedge pclk) disable iff (!presetn)
        $changed(chan_r) |-> dwell_r == $past(dwell_len);
    endproperty
    a_dwell: assert property (p_dwell) else $error("dwell not loaded"); // RQ5

    property p_enc_limit;
        @(posedge pclk) disable iff (!presetn)
        wr && paddr == `AERE_ENC_EN_OFS && enc_too_many |=> $stable(enc_en_r) && enc_err_r;
    endproperty
    a_enc_limit: assert property (p_enc_limit) else $error("encoder limit not enforced"); // RQ12

    property p_enc_ign;
        @(posedge pclk) disable iff (!presetn)
        wr && paddr == `AERE_ENC_EN_OFS && !enc_too_many |=> (enc_en_r & $past(enc_fb_r)) == 8'h00;
    endproperty
    a_enc_ign: assert property (p_enc_ign) else $error("mapped encoder bit stored"); // RQ9

    property p_dac_drop;
        @(posedge pclk) disable iff (!presetn)
        dac_drop |=> !dac_out.valid ##1 irq_stat_r[`AERE_IRQ_DAC_DROP];
    endproperty
    a_dac_drop: assert property (p_dac_drop) else $error("owned output code not dropped"); // RQ16

    property p_dac_raw;
        @(posedge pclk) disable iff (!presetn)
        dac_out.valid |-> dac_out.code == $past(pwdata[15:0]);
    endproperty
    a_dac_raw: assert property (p_dac_raw) else $error("direct code altered"); // RQ13 RQ14

    property p_scan_hold;
        @(posedge pclk) disable iff (!presetn)
        dwell_r > 16'h0001 |=> chan_r == $past(chan_r) && dwell_r == $past(dwell_r) - 16'h0001;
    endproperty
    a_scan_hold: assert property (p_scan_hold) else $error("channel left before dwell ended"); // RQ6

    property p_scan_idle;
        @(posedge pclk) disable iff (!presetn)
        adc_active == 8'h00 |=> !scan.valid;
    endproperty
    a_scan_idle: assert property (p_scan_idle) else $error("sample with no channel enabled"); // RQ7

    property p_dwell_max;
        @(posedge pclk) disable iff (!presetn)
        dwell_r <= DWELL_MAX;
    endproperty
    a_dwell_max: assert property (p_dwell_max) else $error("dwell beyond configured length"); // RQ5

    property p_enc_rst;
        @(posedge pclk) $rose(presetn) |-> enc_en_r == 8'h00 && !irq;
    endproperty
    a_enc_rst: assert property (p_enc_rst) else $error("encoder map not clear after reset"); // RQ8

    property p_enc_write;
        @(posedge pclk) disable iff (!presetn)
        wr && paddr == `AERE_ENC_EN_OFS && !enc_too_many |=>
            enc_en_r == ($past(pwdata[7:0]) & ~$past(enc_fb_r) & ENC_PRESENT);
    endproperty
    a_enc_write: assert property (p_enc_write) else $error("encoder map write wrong"); // RQ8

    property p_enc_absent;
        @(posedge pclk) disable iff (!presetn)
        (enc_en_r & ~ENC_PRESENT) == 8'h00;
    endproperty
    a_enc_absent: assert property (p_enc_absent) else $error("absent encoder enabled"); // RQ10

    property p_adc_err_clr;
        @(posedge pclk) disable iff (!presetn)
        wr && paddr == `AERE_ADC_EN_OFS && !adc_blocked |=> !adc_err_r;
    endproperty
    a_adc_err_clr: assert property (p_adc_err_clr) else $error("adc error left after good write"); // RQ3

    property p_rd_map;
        @(posedge pclk) disable iff (!presetn)
        rd && paddr == `AERE_ADC_EN_OFS |-> prdata == {24'h0, adc_en_r};
    endproperty
    a_rd_map: assert property (p_rd_map) else $error("adc map read back wrong"); // RQ1

    property p_dac_pass;
        @(posedge pclk) disable iff (!presetn)
        wr && paddr == `AERE_DAC_CODE_OFS && !dac_drop |=> dac_out.valid && dac_out.chan == $past(dac_idx);
    endproperty
    a_dac_pass: assert property (p_dac_pass) else $error("free output code not passed"); // RQ13

    property p_dac_idle;
        @(posedge pclk) disable iff (!presetn)
        !(wr && paddr == `AERE_DAC_CODE_OFS && !dac_drop) |=> !dac_out.valid;
    endproperty
    a_dac_idle: assert property (p_dac_idle) else $error("output code without accepted write"); // RQ16

    property p_irq_set;
        @(posedge pclk) disable iff (!presetn)
        ev != 4'h0 |=> (irq_stat_r[3:0] & $past(ev)) == $past(ev);
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("event not latched"); // RQ3 RQ12 RQ16

    property p_unmapped;
        @(posedge pclk) disable iff (!presetn)
        psel && penable && paddr > `AERE_SCAN_OFS |-> pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");

    c_wrap: cover property (@(posedge pclk) disable iff (!presetn) wrap_ev);
    c_adc_err: cover property (@(posedge pclk) disable iff (!presetn) ev[`AERE_IRQ_ADC_ERR]);
    c_dac: cover property (@(posedge pclk) disable iff (!presetn) dac_out.valid);
    c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
    c_read: cover property (@(posedge pclk) disable iff (!presetn) rd);

endmodule : aere_top

// file: testbench/aere_chan_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// channel hardware seen by the block
// ----------------------------------------
module aere_chan_model
    import aere_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input aere_scan_t scan,
    input aere_dac_t dac_out,
    output logic [15:0] scan_cnt,
    output logic [2:0] scan_chan,
    output logic [15:0] ch_gap,
    output logic [15:0] dac_cnt,
    output logic signed [15:0] dac_code,
    output logic [2:0] dac_chan
);
    logic [15:0] now_r;
    logic [15:0] seen_r [8];

    // converter: time stamps each sample, gap is per channel
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            now_r <= 16'h0000;
            scan_cnt <= 16'h0000;
            scan_chan <= 3'h0;
            ch_gap <= 16'h0000;
            for (int i = 0; i < 8; i++) seen_r[i] <= 16'h0000;
        end else begin
            now_r <= now_r + 16'h0001;
            if (scan.valid) begin
                scan_cnt <= scan_cnt + 16'h0001;
                scan_chan <= scan.chan;
                ch_gap <= now_r - seen_r[scan.chan];
                seen_r[scan.chan] <= now_r;
            end
        end
    end

    // output stage: code is taken as is, no limit or offset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_cnt <= 16'h0000;
            dac_code <= 16'sh0000;
            dac_chan <= 3'h0;
        end else if (dac_out.valid) begin
            dac_cnt <= dac_cnt + 16'h0001;
            dac_code <= dac_out.code;
            dac_chan <= dac_out.chan;
        end
    end
endmodule : aere_chan_model

// file: testbench/testbench.sv
`timescale 1ns/10ps
`include "aere_consts.svh"
module testbench;
    import aere_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0] adc_active, enc_active;
    aere_scan_t scan;
    aere_dac_t dac_out;
    logic [15:0] scan_cnt, ch_gap, dac_cnt, c0;
    logic [2:0] scan_chan, dac_chan;
    logic signed [15:0] dac_code;
    int n_errors, n_tests, cyc;

    aere_top #(.NUM_ENC(4), .MAX_ENC(3), .DWELL_SLOW(4), .DWELL_FAST(3)) uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .adc_active(adc_active), .enc_active(enc_active),
        .scan(scan), .dac_out(dac_out));
    aere_chan_model far (.pclk(pclk), .presetn(presetn), .scan(scan), .dac_out(dac_out), .scan_cnt(scan_cnt),
        .scan_chan(scan_chan), .ch_gap(ch_gap), .dac_cnt(dac_cnt), .dac_code(dac_code), .dac_chan(dac_chan));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // ----------------------------------------
    // bus and compare helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string m);
        apb(1'b0, a, 32'h0);
        chk(q, exp, m);
    endtask : rdchk

    function automatic logic [2:0] next_en(input logic [7:0] m, input logic [2:0] c);
        logic [2:0] k;
        k = c + 3'h1;
        while (!m[k]) k = k + 3'h1;
        return k;
    endfunction : next_en

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk(adc_active, 8'hff, "adc reset");
        chk(enc_active, 8'h00, "enc reset");
        rdchk(`AERE_ADC_EN_OFS, 32'h0000_00ff, "adc map reset");
        rdchk(`AERE_ENC_EN_OFS, 32'h0, "enc map reset");
        chk(irq, 1'b0, "irq reset");
    endtask : t_reset

    task automatic t_scan(input logic [7:0] map, input logic fast, input int per, input int cnt);
        logic [2:0] prev;
        wr(`AERE_CFG_OFS, {31'h0, fast});
        wr(`AERE_ADC_EN_OFS, {24'h0, map});
        for (int k = 0; k < 9; k++) begin
            c0 = scan_cnt;
            while (scan_cnt === c0)
                @(posedge pclk);
            if (k > 4) begin
                chk(scan_chan, next_en(map, prev), "scan order");
                chk(ch_gap, per * cnt, "sample interval");
            end
            prev = scan_chan;
        end
    endtask : t_scan

    task automatic t_adc();
        wr(`AERE_ADC_FB_OFS, 32'h2);
        wr(`AERE_AXIS_EN_OFS, 32'h2);
        wr(`AERE_IRQ_STAT_OFS, 32'hf);
        wr(`AERE_IRQ_MASK_OFS, 32'h1);
        chk(adc_active, 8'h83, "fb follows axis");
        wr(`AERE_ADC_EN_OFS, 32'h2);
        rdchk(`AERE_ADC_EN_OFS, 32'h81, "refused map kept");
        rdchk(`AERE_STAT_OFS, 32'h0001_0083, "adc error flag");
        chk(irq, 1'b1, "adc error irq");
        wr(`AERE_IRQ_STAT_OFS, 32'h1);
        chk(irq, 1'b0, "irq cleared");
        wr(`AERE_ADC_EN_OFS, 32'h11);
        chk(adc_active, 8'h13, "map accepted");
        wr(`AERE_AXIS_EN_OFS, 32'h0);
        chk(adc_active, 8'h11, "fb off with axis");
    endtask : t_adc

    task automatic t_enc();
        wr(`AERE_ENC_FB_OFS, 32'h2);
        wr(`AERE_AXIS_EN_OFS, 32'h2);
        chk(enc_active, 8'h02, "enc follows axis");
        wr(`AERE_ENC_EN_OFS, 32'hf5);
        rdchk(`AERE_ENC_EN_OFS, 32'h05, "ignored bits");
        chk(enc_active, 8'h07, "enc active");
        wr(`AERE_IRQ_MASK_OFS, 32'h2);
        wr(`AERE_ENC_EN_OFS, 32'h0d);
        chk(enc_active, 8'h07, "too many refused");
        chk(irq, 1'b1, "enc error irq");
        wr(`AERE_IRQ_STAT_OFS, 32'h2);
        wr(`AERE_AXIS_EN_OFS, 32'h0);
        chk(enc_active, 8'h05, "enc off with axis");
        chk(irq, 1'b0, "irq cleared");
    endtask : t_enc

    task automatic t_dac();
        wr(`AERE_DAC_MAP_OFS, 32'h8);
        wr(`AERE_DAC_SEL_OFS, 32'h2);
        c0 = dac_cnt;
        wr(`AERE_DAC_CODE_OFS, 32'h8000);
        @(posedge pclk);
        chk(dac_cnt, c0 + 16'h1, "dac taken");
        chk({16'h0, dac_code}, 32'h8000, "dac low end");
        chk(dac_chan, 3'h2, "dac chan");
        wr(`AERE_DAC_CODE_OFS, 32'h7fff);
        @(posedge pclk);
        chk({16'h0, dac_code}, 32'h7fff, "dac high end");
        wr(`AERE_DAC_SEL_OFS, 32'h3);
        wr(`AERE_AXIS_EN_OFS, 32'h8);
        wr(`AERE_IRQ_MASK_OFS, 32'h4);
        c0 = dac_cnt;
        wr(`AERE_DAC_CODE_OFS, 32'h1234);
        @(posedge pclk);
        chk(dac_cnt, c0, "owned output dropped");
        chk(irq, 1'b1, "drop irq");
        rdchk(`AERE_DAC_CODE_OFS, 32'h7fff, "code kept");
        apb(1'b0, 12'hffc, 32'h0);
        chk(e, 1'b1, "unmapped error");
    endtask : t_dac

    task automatic print_verdict();
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict

    // ----------------------------------------
    // sequence and hang guard
    // ----------------------------------------
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            print_verdict();
        end
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        n_errors = 0;
        n_tests = 0;
        cyc = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_scan(8'h25, 1'b0, 4, 3);
        t_scan(8'h81, 1'b1, 3, 2);
        t_adc();
        t_enc();
        t_dac();
        print_verdict();
    end
endmodule : testbench
